// >>> shared/acs_cfg.svh
/*
 * Offsets, field positions, reset values and timing counts of the
 * calibration and power-down sequencer.
 * Assumes it is included once per compilation unit by its bare name.
 */
`ifndef ACS_CFG_SVH
`define ACS_CFG_SVH

// ==========================================================
// Register word indices (byte address = index * 4)
`define ACS_IDX_CTRL 3'h0
`define ACS_IDX_STATUS 3'h1
`define ACS_IDX_DATA 3'h2
`define ACS_IDX_OFS0 3'h3
`define ACS_IDX_GAIN0 3'h4
`define ACS_IDX_OFS1 3'h5
`define ACS_IDX_GAIN1 3'h6

// ==========================================================
// Control word bit positions
`define ACS_B_SLEEP 0
`define ACS_B_HOLD 1
`define ACS_B_MODE_LO 2
`define ACS_B_MODE_HI 3
`define ACS_B_CLKDIV 4
`define ACS_B_FSEL0 5
`define ACS_B_FSEL1 6
`define ACS_B_BIPOLAR 7
`define ACS_B_CHAN 8
`define ACS_B_INHIBIT 9
`define ACS_B_INT_OSC 10

// ==========================================================
// Reset values
`define ACS_HOLD_RST 1'b1
`define ACS_BIPOLAR_RST 1'b1

// ==========================================================
// Timing, in output periods or master clock cycles
`define ACS_CAL_PERIODS 2'h3
`define ACS_CONV_FIRST_PERIODS 2'h3
`define ACS_CONV_SYS_PERIODS 2'h1
`define ACS_TP_MCLK 16'h07D0
`define ACS_MOD_CYCLE_SHIFT 7

// Decimation rates, selected by {clkdiv, fsel}
`define ACS_DEC_0 9'h187
`define ACS_DEC_1 9'h139
`define ACS_DEC_2 9'h04E
`define ACS_DEC_3 9'h027
`define ACS_DEC_4 9'h180
`define ACS_DEC_5 9'h140
`define ACS_DEC_6 9'h04D
`define ACS_DEC_7 9'h026

`endif

// >>> shared/acs_pkg.sv
/*
 * Types of the calibration and power-down sequencer.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package acs_pkg;
	typedef enum logic [2:0] {
		ACS_IDLE = 3'b000,
		ACS_CALZ = 3'b001,
		ACS_CALF = 3'b010,
		ACS_CONV = 3'b011,
		ACS_PIPE = 3'b100
	} acs_state_e;

	typedef struct packed {
		acs_state_e st;
		logic [1:0] rem;
		logic self_cal;
		logic mode_hi;
		logic mode_lo;
		logic sleep;
		logic hold;
		logic clkdiv;
		logic [1:0] fsel;
		logic bipolar;
		logic chan;
		logic inhibit;
		logic int_osc;
		logic rr_n;
		logic [15:0] data;
		logic [1:0][15:0] ofs;
		logic [1:0][15:0] gain;
		logic busy;
		logic a_wr;
		logic [2:0] a_idx;
		logic [31:0] rdata;
		logic [2:0] msync;
		logic clk_out;
	} acs_state_s;

	typedef struct packed {
		logic [15:0] cnt;
	} acs_tmr_s;
endpackage

// >>> logic/acs_tick_timer.sv
/*
 * Counts enable ticks and pulses done on the tick that reaches limit.
 * Assumes tick is a one-cycle enable on clk_sys and limit is nonzero.
 */
`timescale 1ns/100ps
module acs_tick_timer (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic restart,
	input wire logic tick,
	input wire logic [15:0] limit,
	output logic done
);
	import acs_pkg::*;

	acs_tmr_s state_q;
	acs_tmr_s state_d;

	// Done does not look at restart, so a caller may restart on done
	assign done = tick & (state_q.cnt == limit - 16'h1);

	always_comb begin
		state_d = state_q;
		if (restart) begin
			state_d.cnt = 16'h0;
		end else if (done) begin
			state_d.cnt = 16'h0;
		end else if (tick) begin
			state_d.cnt = state_q.cnt + 16'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end
endmodule

// >>> logic/acs_sequencer.sv
/*
 * Calibration, conversion timing and power-down sequencer with an
 * AHB-Lite register slave.
 * Assumes one AHB-Lite master, word transfers only, and a master clock
 * pin that is asynchronous to clk_sys and much slower than it.
 */
// The register offsets and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/100ps
`include "acs_cfg.svh"

module acs_sequencer (
	input wire logic clk_sys,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic master_clock_input,
	input wire logic [15:0] sample_data,
	output logic result_ready_n,
	output logic clock_output_pin,
	output logic osc_enable,
	output logic modulator_run,
	output logic short_inputs_en,
	output logic ref_apply_en
);
	import acs_pkg::*;

	acs_state_s state_q;
	acs_state_s state_d;
	logic mtick;
	logic [8:0] dec;
	logic [15:0] per_limit;
	logic per_done;
	logic pipe_done;
	logic restart;
	logic clk_out_en;

	// ==========================================================
	// Master clock edges and output period
	// Only the second and third sync stages feed the edge detector.
	assign mtick = state_q.msync[1] & ~state_q.msync[2];

	always_comb begin
		unique case ({state_q.clkdiv, state_q.fsel})
			3'h0: dec = `ACS_DEC_0;
			3'h1: dec = `ACS_DEC_1;
			3'h2: dec = `ACS_DEC_2;
			3'h3: dec = `ACS_DEC_3;
			3'h4: dec = `ACS_DEC_4;
			3'h5: dec = `ACS_DEC_5;
			3'h6: dec = `ACS_DEC_6;
			3'h7: dec = `ACS_DEC_7;
		endcase
	end

	// One modulator cycle per decimation step; fits 16 bits for all rates
	assign per_limit = {dec, {`ACS_MOD_CYCLE_SHIFT{1'b0}}};

	acs_tick_timer u_period (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.restart(restart),
		.tick(mtick & (state_q.st != ACS_IDLE)),
		.limit(per_limit),
		.done(per_done)
	);

	acs_tick_timer u_pipe (
		.clk_sys(clk_sys),
		.rstn(rstn),
		.restart(restart),
		.tick(mtick & (state_q.st == ACS_PIPE)),
		.limit(`ACS_TP_MCLK),
		.done(pipe_done)
	);

	// ==========================================================
	// Outputs
	assign hreadyout = ~state_q.busy;
	assign hresp = 1'b0;
	assign hrdata = state_q.rdata;
	assign result_ready_n = state_q.rr_n;
	assign clock_output_pin = state_q.clk_out;
	assign modulator_run = ~state_q.hold & ~state_q.sleep;
	assign osc_enable = ~(state_q.sleep & state_q.int_osc);
	// External source keeps the output alive in power-down
	assign clk_out_en = ~state_q.inhibit & osc_enable;
	assign short_inputs_en = state_q.self_cal & (state_q.st == ACS_CALZ);
	assign ref_apply_en = state_q.self_cal & (state_q.st == ACS_CALF);

	// ==========================================================
	// Next state
	always_comb begin
		logic wr_ctrl;
		logic rd_data;
		logic hold_fall;
		logic sleep_fall;
		logic cal_go;
		logic [15:0] zs;
		wr_ctrl = 1'b0;
		rd_data = 1'b0;
		hold_fall = 1'b0;
		sleep_fall = 1'b0;
		cal_go = 1'b0;
		zs = 16'h0;
		state_d = state_q;
		restart = 1'b0;
		state_d.msync = {state_q.msync[1:0], master_clock_input};
		state_d.clk_out = state_q.msync[1] & clk_out_en;

		// Bus data phase: one wait cycle, then read data from a flop
		if (state_q.busy) begin
			state_d.busy = 1'b0;
			state_d.rdata = 32'h0;
			if (state_q.a_wr) begin
				unique case (state_q.a_idx)
					`ACS_IDX_CTRL: begin
						wr_ctrl = 1'b1;
						state_d.sleep = hwdata[`ACS_B_SLEEP];
						state_d.hold = hwdata[`ACS_B_HOLD];
						state_d.mode_lo = hwdata[`ACS_B_MODE_LO];
						state_d.mode_hi = hwdata[`ACS_B_MODE_HI];
						state_d.clkdiv = hwdata[`ACS_B_CLKDIV];
						state_d.fsel = hwdata[`ACS_B_FSEL1:`ACS_B_FSEL0];
						state_d.bipolar = hwdata[`ACS_B_BIPOLAR];
						state_d.chan = hwdata[`ACS_B_CHAN];
						state_d.inhibit = hwdata[`ACS_B_INHIBIT];
						state_d.int_osc = hwdata[`ACS_B_INT_OSC];
					end
					`ACS_IDX_OFS0: state_d.ofs[0] = hwdata[15:0];
					`ACS_IDX_GAIN0: state_d.gain[0] = hwdata[15:0];
					`ACS_IDX_OFS1: state_d.ofs[1] = hwdata[15:0];
					`ACS_IDX_GAIN1: state_d.gain[1] = hwdata[15:0];
					default: ;
				endcase
			end else begin
				unique case (state_q.a_idx)
					`ACS_IDX_CTRL: state_d.rdata = {21'h0,
						state_q.int_osc, state_q.inhibit,
						state_q.chan, state_q.bipolar,
						state_q.fsel, state_q.clkdiv,
						state_q.mode_hi, state_q.mode_lo,
						state_q.hold, state_q.sleep};
					`ACS_IDX_STATUS: state_d.rdata = {26'h0,
						state_q.st, state_q.sleep,
						state_q.mode_hi | state_q.mode_lo,
						state_q.rr_n};
					`ACS_IDX_DATA: begin
						rd_data = 1'b1;
						state_d.rdata = {16'h0, state_q.data};
					end
					`ACS_IDX_OFS0: state_d.rdata = {16'h0, state_q.ofs[0]};
					`ACS_IDX_GAIN0: state_d.rdata = {16'h0, state_q.gain[0]};
					`ACS_IDX_OFS1: state_d.rdata = {16'h0, state_q.ofs[1]};
					`ACS_IDX_GAIN1: state_d.rdata = {16'h0, state_q.gain[1]};
					default: state_d.rdata = 32'h0;
				endcase
			end
		end
		if (hsel & htrans[1] & hready) begin
			state_d.busy = 1'b1;
			state_d.a_wr = hwrite;
			// Anything above the last register reads zero
			state_d.a_idx = (haddr[31:5] == 27'h0) ? haddr[4:2] : 3'h7;
		end

		// A completed data read frees the flag, also in power-down
		if (rd_data) begin
			state_d.rr_n = 1'b1;
		end

		hold_fall = state_q.hold & ~state_d.hold;
		sleep_fall = state_q.sleep & ~state_d.sleep;
		cal_go = (state_d.mode_hi | state_d.mode_lo) & ~state_d.hold &
			~state_d.sleep & (wr_ctrl | hold_fall | sleep_fall);
		// Offset code is kept relative to the zero point of the transfer
		zs = state_d.bipolar ? (sample_data ^ 16'h8000) : sample_data;

		if (state_d.hold | state_d.sleep) begin
			// Registers and the flag are left as they are
			state_d.st = ACS_IDLE;
		end else if (cal_go) begin
			// Raised at once, well inside one modulator cycle
			state_d.rr_n = 1'b1;
			restart = 1'b1;
			state_d.rem = `ACS_CAL_PERIODS;
			state_d.self_cal = ~state_d.mode_hi & state_d.mode_lo;
			state_d.st = (state_d.mode_hi & state_d.mode_lo) ?
				ACS_CALF : ACS_CALZ;
		end else if (hold_fall | sleep_fall) begin
			restart = 1'b1;
			state_d.rem = `ACS_CONV_FIRST_PERIODS;
			state_d.st = sleep_fall ? ACS_PIPE : ACS_CONV;
		end else begin
			unique case (state_q.st)
				ACS_IDLE: ;
				ACS_CALZ: if (per_done) begin
					if (state_q.rem == 2'h1) begin
						state_d.ofs[state_q.chan] = zs;
						if (state_q.self_cal) begin
							state_d.rem = `ACS_CAL_PERIODS;
							state_d.st = ACS_CALF;
						end else begin
							state_d.mode_hi = 1'b0;
							state_d.mode_lo = 1'b0;
							state_d.rem = `ACS_CONV_SYS_PERIODS;
							state_d.st = ACS_CONV;
						end
					end else begin
						state_d.rem = state_q.rem - 2'h1;
					end
				end
				ACS_CALF: if (per_done) begin
					if (state_q.rem == 2'h1) begin
						// Span from the zero point to positive full scale
						state_d.gain[state_q.chan] =
							zs - state_q.ofs[state_q.chan];
						state_d.mode_hi = 1'b0;
						state_d.mode_lo = 1'b0;
						state_d.rem = state_q.self_cal ?
							`ACS_CONV_FIRST_PERIODS :
							`ACS_CONV_SYS_PERIODS;
						state_d.st = ACS_CONV;
					end else begin
						state_d.rem = state_q.rem - 2'h1;
					end
				end
				ACS_CONV: if (per_done) begin
					if (state_q.rem == 2'h1) begin
						// New result wins over a read in the same cycle
						state_d.data = sample_data;
						state_d.rr_n = 1'b0;
						state_d.rem = 2'h1;
					end else begin
						state_d.rem = state_q.rem - 2'h1;
					end
				end
				ACS_PIPE: if (pipe_done) begin
					restart = 1'b1;
					state_d.st = ACS_CONV;
				end
				default: state_d.st = ACS_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_sys or negedge rstn) begin
		if (!rstn) begin
			state_q <= '0;
			state_q.hold <= `ACS_HOLD_RST;
			state_q.bipolar <= `ACS_BIPOLAR_RST;
			state_q.rr_n <= 1'b1;
		end else begin
			state_q <= state_d;
		end
	end

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rstn);

	sequence s_self_zero_end;
		state_q.st == ACS_CALZ && state_q.self_cal && per_done &&
			state_q.rem == 2'h1 && !state_d.hold && !state_d.sleep &&
			!state_q.busy;
	endsequence
	sequence s_in_full;
		state_q.st == ACS_CALF && state_q.rem == 2'h3;
	endsequence

	AST_CAL_RAISE: assert property (
		(state_q.st != ACS_CALZ && state_d.st == ACS_CALZ) |=> result_ready_n)
		else $error("ready not high after calibration start");
	AST_ZERO_THEN_FULL: assert property (
		s_self_zero_end |=> s_in_full ##0 ref_apply_en && !short_inputs_en)
		else $error("self calibration did not move to full scale");
	AST_MODE_CLEAR: assert property (
		(state_q.st == ACS_CALF && per_done && state_q.rem == 2'h1 &&
			!state_q.busy && !state_d.hold && !state_d.sleep) |=>
			!state_q.mode_hi && !state_q.mode_lo && state_q.st == ACS_CONV)
		else $error("mode bits not cleared at calibration end");
	AST_SLEEP_KEEP: assert property (
		$rose(state_q.sleep) |-> result_ready_n == $past(result_ready_n))
		else $error("entering sleep changed ready");
	AST_NO_FALL_ASLEEP: assert property (
		$fell(result_ready_n) |-> !$past(state_q.sleep))
		else $error("ready fell during power-down");
	AST_READ_RAISE: assert property (
		(state_q.busy && !state_q.a_wr && state_q.a_idx == `ACS_IDX_DATA &&
			!(state_q.st == ACS_CONV && per_done)) |=> result_ready_n)
		else $error("ready not raised by data read");
	AST_HOLD_STOPS: assert property (
		state_q.hold |-> state_q.st == ACS_IDLE && !modulator_run)
		else $error("activity while hold is set");
	AST_OSC_OFF: assert property (
		state_q.sleep && state_q.int_osc |=> !clock_output_pin)
		else $error("internal oscillator runs in power-down");
	AST_CLOCK_OUTPUT_PIN_RUN: assert property (
		(!state_q.int_osc && !state_q.inhibit && state_q.sleep)
			[*2] |-> clock_output_pin == $past(state_q.msync[1]))
		else $error("clock output stopped in power-down");
	AST_RETAIN: assert property (
		(state_q.sleep && !state_q.busy) |=> $stable(state_q.ofs) &&
			$stable(state_q.gain) && $stable(state_q.data))
		else $error("register changed in power-down");
	AST_PIPE_EXIT: assert property (
		(state_q.st == ACS_PIPE && pipe_done && !state_d.hold &&
			!state_d.sleep && !state_q.busy) |=>
			state_q.st == ACS_CONV && state_q.rem == 2'h3)
		else $error("pipeline delay did not lead to conversion");
endmodule

// >>> tb/acs_far_model.sv
/*
 * Far-side model: the free-running master clock source and the
 * analog level that the filter turns into sample data.
 * Assumes the bench sets level on clk_sys and reads mclk_edges.
 */
`timescale 1ns/100ps
module acs_far_model #(
	parameter real HALF_NS = 80.0
) (
	input wire logic [15:0] level,
	output logic master_clock_input,
	output logic [15:0] sample_data,
	output logic [31:0] mclk_edges
);
	// ==========================================================
	// Master clock
	// Runs free and never stops, so no settling wait is needed
	initial begin
		master_clock_input = 1'b0;
		#7.3;
		forever #(HALF_NS) master_clock_input = ~master_clock_input;
	end

	// Rising edges of the master clock since time zero
	logic [31:0] count_q = 32'h0;

	assign mclk_edges = count_q;

	always @(posedge master_clock_input) begin
		count_q <= count_q + 32'h1;
	end

	// ==========================================================
	// Applied input
	// The level is in place before each calibration command
	assign sample_data = level;
endmodule

// >>> tb/test_adc_calibration_powerdown_sequencer.sv
/*
 * Self-checking bench of the sequencer: AHB-Lite register access,
 * power-down behaviour and a zero-scale system calibration timed in
 * master clock edges.
 * Assumes the far-side model supplies a 160 ns master clock.
 */
`timescale 1ns/100ps
module test_adc_calibration_powerdown_sequencer;
	logic clk_sys;
	logic rstn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic master_clock_input;
	logic [15:0] sample_data;
	logic [15:0] level = 16'h0;
	logic [31:0] edges;
	logic result_ready_n;
	logic clock_output_pin;
	logic osc_enable;
	logic modulator_run;
	logic short_inputs_en;
	logic ref_apply_en;
	int bad_count = 0;
	int samples_checked = 0;
	logic [31:0] seed = 32'h3711;

	assign hready = hreadyout;

	acs_sequencer acs_sequencer_inst (
		.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata),
		.master_clock_input(master_clock_input),
		.sample_data(sample_data), .result_ready_n(result_ready_n),
		.clock_output_pin(clock_output_pin), .osc_enable(osc_enable),
		.modulator_run(modulator_run),
		.short_inputs_en(short_inputs_en), .ref_apply_en(ref_apply_en)
	);

	acs_far_model #(.HALF_NS(80.0)) acs_far_model_inst (
		.level(level), .master_clock_input(master_clock_input),
		.sample_data(sample_data), .mclk_edges(edges)
	);

	// ==========================================================
	// Clock, helpers and bus tasks
	initial begin
		clk_sys = 1'b0;
		forever #10 clk_sys = ~clk_sys;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Master edges in one output period for a {clkdiv, fsel} setting
	function automatic logic [31:0] period_edges(input logic [2:0] sel);
		logic [31:0] dec;
		case (sel)
			3'h0: dec = 32'd391;
			3'h1: dec = 32'd313;
			3'h2: dec = 32'd78;
			3'h3: dec = 32'd39;
			3'h4: dec = 32'd384;
			3'h5: dec = 32'd320;
			3'h6: dec = 32'd77;
			default: dec = 32'd38;
		endcase
		return 32'd128 * dec;
	endfunction

	task automatic check(input string name, input logic [31:0] exp,
			input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic ahb(input logic w, input logic [31:0] a,
			input logic [31:0] wd, output logic [31:0] rd);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clk_sys); while (hready !== 1'b1);
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge clk_sys); while (hready !== 1'b1);
		rd = hrdata;
		hsel <= 1'b0;
	endtask

	task automatic wait_edge(input logic [31:0] n);
		while (edges < n) @(posedge clk_sys);
	endtask

	task automatic finish_test;
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	initial begin
		#6000000;
		bad_count++;
		$display("watchdog expired");
		finish_test();
	end

	// ==========================================================
	// Test sequence
	initial begin
		logic [31:0] rd;
		logic [31:0] ofs_val;
		logic [31:0] gain_val;
		logic [31:0] t0;
		logic [31:0] per;
		int toggles;
		logic prev_pin;
		repeat (12) @(posedge clk_sys);
		rstn <= 1'b1;
		@(posedge clk_sys);
		check("ready", 32'h1, result_ready_n);
		check("hreadyout", 32'h1, hreadyout);
		check("modulator_run", 32'h0, modulator_run);
		check("osc_enable", 32'h1, osc_enable);
		ahb(1'b0, 32'h0, 32'h0, rd);
		check("ctrl reset", 32'h82, rd);
		ahb(1'b0, 32'h4, 32'h0, rd);
		check("status reset", 32'h1, rd);
		check("hresp", 32'h0, hresp);
		seed = lfsr(seed);
		ofs_val = {16'h0, seed[15:0]};
		seed = lfsr(seed);
		gain_val = {16'h0, seed[15:0]};
		ahb(1'b1, 32'hC, ofs_val, rd);
		ahb(1'b1, 32'h18, gain_val, rd);
		ahb(1'b1, 32'h1C, 32'hFFFF, rd);
		ahb(1'b0, 32'h1C, 32'h0, rd);
		check("unmapped", 32'h0, rd);
		ahb(1'b0, 32'hC, 32'h0, rd);
		check("ofs0", ofs_val, rd);
		ahb(1'b0, 32'h18, 32'h0, rd);
		check("gain1", gain_val, rd);
		$display("test registers done");

		// Sleep on the internal oscillator, then on an external clock
		ahb(1'b1, 32'h0, 32'h403, rd);
		repeat (2) @(posedge clk_sys);
		check("osc_enable", 32'h0, osc_enable);
		check("ready", 32'h1, result_ready_n);
		ahb(1'b0, 32'hC, 32'h0, rd);
		check("ofs0 sleep", ofs_val, rd);
		ahb(1'b1, 32'h0, 32'h3, rd);
		toggles = 0;
		prev_pin = clock_output_pin;
		repeat (64) begin
			@(posedge clk_sys);
			if (clock_output_pin !== prev_pin) toggles++;
			prev_pin = clock_output_pin;
		end
		check("clock out runs", 32'h1, toggles >= 4);
		ahb(1'b1, 32'h0, 32'h2, rd);
		$display("test power-down done");

		// Zero-scale system calibration, channel 1, unipolar, dec 38
		seed = lfsr(seed);
		level <= seed[15:0];
		per = period_edges(3'h7);
		ahb(1'b1, 32'h0, 32'h178, rd);
		t0 = edges;
		@(posedge clk_sys);
		check("ready cal", 32'h1, result_ready_n);
		check("modulator_run", 32'h1, modulator_run);
		check("short_inputs_en", 32'h0, short_inputs_en);
		check("ref_apply_en", 32'h0, ref_apply_en);
		wait_edge(t0 + 3 * per - 3);
		ahb(1'b0, 32'h0, 32'h0, rd);
		check("mode early", 32'h178, rd);
		wait_edge(t0 + 3 * per + 3);
		ahb(1'b0, 32'h0, 32'h0, rd);
		check("mode cleared", 32'h170, rd);
		wait_edge(t0 + 4 * per - 3);
		check("ready early", 32'h1, result_ready_n);
		wait_edge(t0 + 4 * per + 3);
		check("ready result", 32'h0, result_ready_n);
		ahb(1'b0, 32'h14, 32'h0, rd);
		check("ofs1", {16'h0, level}, rd);
		ahb(1'b0, 32'hC, 32'h0, rd);
		check("ofs0 kept", ofs_val, rd);
		$display("test calibration done");

		// Sleep with an unread result, then read it
		ahb(1'b1, 32'h0, 32'h171, rd);
		@(posedge clk_sys);
		check("ready sleep", 32'h0, result_ready_n);
		check("modulator_run", 32'h0, modulator_run);
		ahb(1'b0, 32'h8, 32'h0, rd);
		check("data", {16'h0, level}, rd);
		@(posedge clk_sys);
		check("ready read", 32'h1, result_ready_n);
		repeat (200) @(posedge clk_sys);
		check("ready held", 32'h1, result_ready_n);
		ahb(1'b1, 32'h0, 32'h172, rd);
		$display("test sleep read done");
		finish_test();
	end
endmodule
